// ### logic/psc_pkg.sv
package psc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // apb map
    localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET = 8'h04;
    localparam int          ADDR_W        = 8;

    ////////////////////////////////////////////////////////////////////////
    // control register layout
    localparam int          CTRL_W        = 16;
    localparam int          ENABLE_BIT    = 15;
    localparam int          SEL_LSB       = 0;
    localparam int          SEL_W         = 3;
    localparam logic        ENABLE_RESET  = 1'b0;
    localparam logic [2:0]  SEL_RESET     = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // status register layout
    localparam int          ST_HALF_LSB   = 0;
    localparam int          ST_PEND_BIT   = 8;
    localparam int          ST_CLK_BIT    = 9;
    localparam int          ST_EN_BIT     = 10;

    ////////////////////////////////////////////////////////////////////////
    // divide select codes and half periods in pclk cycles
    localparam logic [2:0]  SEL_BY1       = 3'h0;
    localparam logic [2:0]  SEL_BY4       = 3'h1;
    localparam logic [2:0]  SEL_BY8       = 3'h2;
    localparam logic [2:0]  SEL_BY16      = 3'h3;
    localparam logic [2:0]  SEL_BY32      = 3'h4;
    localparam logic [2:0]  SEL_BY64      = 3'h5;
    localparam int          HALF_W        = 7;
    localparam logic [6:0]  HALF_BY1      = 7'h01;
    localparam logic [6:0]  HALF_BY4      = 7'h04;
    localparam logic [6:0]  HALF_BY8      = 7'h08;
    localparam logic [6:0]  HALF_BY16     = 7'h10;
    localparam logic [6:0]  HALF_BY32     = 7'h20;
    localparam logic [6:0]  HALF_BY64     = 7'h40;
    localparam logic [6:0]  CNT_RESET     = 7'h00;

endpackage : psc_pkg

// ### logic/psc_clk_if.sv
`timescale 1ns/100ps
interface psc_clk_if;
    logic [psc_pkg::HALF_W-1:0] half_len;
    logic                       clk_level;
    logic                       rise_tick;

    modport ctrl (output half_len, input clk_level, input rise_tick);
    modport gen  (input half_len, output clk_level, output rise_tick);
endinterface : psc_clk_if

// ### logic/psc_sync.sv
`timescale 1ns/100ps
module psc_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } psc_sync_state_t;

    psc_sync_state_t s_q;
    psc_sync_state_t s_d;

    // first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            s_d.meta[i]   = async_in[i];
            s_d.stable[i] = s_q.meta[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule : psc_sync

// ### logic/psc_clkgen.sv
`timescale 1ns/100ps
module psc_clkgen (
    input  wire logic pclk,
    input  wire logic presetn,
    psc_clk_if.gen    cif
);

    typedef struct packed {
        logic [psc_pkg::HALF_W-1:0] cnt;
        logic                       clk;
        logic                       tick;
    } psc_gen_state_t;

    psc_gen_state_t s_q;
    psc_gen_state_t s_d;
    logic           toggle;

    // comparing with >= lets a new, shorter half period end the current one
    // at once, yet every half period lasts at least one pclk: no runt pulse
    always_comb begin
        toggle   = ({1'b0, s_q.cnt} + 8'h01) >= {1'b0, cif.half_len};
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (toggle) begin
            s_d.cnt  = psc_pkg::CNT_RESET;
            s_d.clk  = ~s_q.clk;
            s_d.tick = ~s_q.clk;
        end else begin
            s_d.cnt = s_q.cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cif.clk_level = s_q.clk;
    assign cif.rise_tick = s_q.tick;

endmodule : psc_clkgen

// ### logic/psc_top.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module psc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        nmi_pin,
    input  wire logic        irq_to_core,
    input  wire logic        third_bus_state_fall,
    input  wire logic        core_idle,
    output logic             clock_output_pin,
    output logic             core_clk_en,
    output logic             periph_clk_en
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                        enable;
        logic [psc_pkg::SEL_W-1:0]   sel;
        logic                        exit_pend;
        logic [31:0]                 rdata;
        logic                        err;
        logic                        core_en;
        logic                        periph_en;
    } psc_top_state_t;

    psc_top_state_t s_q;
    psc_top_state_t s_d;

    psc_clk_if      cif ();
    logic           nmi_s;
    logic           access;
    logic           setup;
    logic           wr_ctrl;
    logic           hit_ctrl;
    logic           hit_status;
    logic           exit_req;

    ////////////////////////////////////////////////////////////////////////
    // divide select decode, reserved codes fall back to undivided

    function automatic logic [psc_pkg::HALF_W-1:0] half_of(
        input logic                      en,
        input logic [psc_pkg::SEL_W-1:0] code
    );
        logic [psc_pkg::HALF_W-1:0] h;
        h = psc_pkg::HALF_BY1;
        if (en) begin
            unique case (code)
                psc_pkg::SEL_BY4:  h = psc_pkg::HALF_BY4;
                psc_pkg::SEL_BY8:  h = psc_pkg::HALF_BY8;
                psc_pkg::SEL_BY16: h = psc_pkg::HALF_BY16;
                psc_pkg::SEL_BY32: h = psc_pkg::HALF_BY32;
                psc_pkg::SEL_BY64: h = psc_pkg::HALF_BY64;
                default:           h = psc_pkg::HALF_BY1;
            endcase
        end
        return h;
    endfunction : half_of

    function automatic logic [31:0] ctrl_image(
        input logic                      en,
        input logic [psc_pkg::SEL_W-1:0] code
    );
        logic [31:0] v;
        v                                               = 32'h0000_0000;
        v[psc_pkg::ENABLE_BIT]                          = en;
        v[psc_pkg::SEL_LSB +: psc_pkg::SEL_W]           = code;
        return v;
    endfunction : ctrl_image

    function automatic logic [31:0] status_image(
        input logic [psc_pkg::HALF_W-1:0] half,
        input logic                       pend,
        input logic                       level,
        input logic                       en
    );
        logic [31:0] v;
        v                                          = 32'h0000_0000;
        v[psc_pkg::ST_HALF_LSB +: psc_pkg::HALF_W] = half;
        v[psc_pkg::ST_PEND_BIT]                    = pend;
        v[psc_pkg::ST_CLK_BIT]                     = level;
        v[psc_pkg::ST_EN_BIT]                      = en;
        return v;
    endfunction : status_image

    ////////////////////////////////////////////////////////////////////////
    // nmi arrives from a pin; the interrupt controller runs on pclk

    psc_sync #(.W(1)) u_nmi_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (nmi_pin),
        .sync_out (nmi_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode; the third bus state comes in on third_bus_state_fall, not from the apb access

    assign access     = psel && penable;
    assign setup      = psel && !penable;
    assign hit_ctrl   = paddr == psc_pkg::CTRL_OFFSET;
    assign hit_status = paddr == psc_pkg::STATUS_OFFSET;
    assign wr_ctrl    = access && pwrite && hit_ctrl;
    // software interrupts have no input here, so they cannot end the mode
    assign exit_req   = nmi_s || irq_to_core;

    always_comb begin
        s_d           = s_q;
        s_d.core_en   = 1'b0;
        s_d.periph_en = 1'b0;

        // exit waits for a bus third-state edge; which cycle is left open
        if (s_q.exit_pend && third_bus_state_fall) begin
            s_d.enable = 1'b0;
        end

        // write wins over the hardware clear; only a write ever sets enable
        if (wr_ctrl) begin
            s_d.enable = pwdata[psc_pkg::ENABLE_BIT];
            s_d.sel    = pwdata[psc_pkg::SEL_LSB +: psc_pkg::SEL_W];
        end
        // pending lives only while the mode stays on: a request that outlasts
        // the clear must not end a later power-save period
        s_d.exit_pend = (s_q.exit_pend || (exit_req && s_q.enable)) && s_d.enable;

        // loaded in the setup cycle so that it stands from a flop all through
        // the zero-wait access phase
        s_d.err   = setup && !(hit_ctrl || hit_status);
        s_d.rdata = 32'h0000_0000;
        if (setup && !pwrite && hit_ctrl) begin
            s_d.rdata = ctrl_image(s_q.enable, s_q.sel);
        end else if (setup && !pwrite && hit_status) begin
            s_d.rdata = status_image(cif.half_len,
                                     s_q.exit_pend,
                                     cif.clk_level,
                                     s_q.enable);
        end

        // idle gates only the core; peripherals keep the divided rate
        s_d.periph_en = cif.rise_tick;
        s_d.core_en   = cif.rise_tick && !core_idle;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.enable <= psc_pkg::ENABLE_RESET;
            s_q.sel    <= psc_pkg::SEL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock generator; new ratio is seen the edge after the write

    assign cif.half_len = half_of(s_q.enable, s_q.sel);

    psc_clkgen u_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign clock_output_pin = cif.clk_level;
    assign core_clk_en      = s_q.core_en;
    assign periph_clk_en    = s_q.periph_en;
    // zero wait: read data and error were registered in the setup cycle
    assign pready           = 1'b1;
    assign prdata           = s_q.rdata;
    assign pslverr          = s_q.err;

endmodule : psc_top

// ### logic/psc_unused_none.sv
`timescale 1ns/100ps

// ### dv/psc_chk.sv
`timescale 1ns/100ps
module psc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nmi_pin,
    input wire logic        irq_to_core,
    input wire logic        third_bus_state_fall,
    input wire logic        core_idle,
    input wire logic        clock_output_pin,
    input wire logic        core_clk_en,
    input wire logic        periph_clk_en
);
    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic wr_c;
    logic undiv;
    assign acc   = psel && penable;
    assign wr_c  = acc && pwrite && paddr == psc_pkg::CTRL_OFFSET;
    // reserved codes count as undivided
    assign undiv = !pwdata[15] || pwdata[2:0] == 3'h0 || pwdata[2:1] == 2'h3;
    ////////////////////////////////////////////////////////////////////////
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_unmap;
        acc && paddr != psc_pkg::CTRL_OFFSET && paddr != psc_pkg::STATUS_OFFSET
        |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access");
    property p_ctrl_rd;
        acc && !pwrite && paddr == psc_pkg::CTRL_OFFSET
        |-> !pslverr && prdata[31:16] == 16'h0 && prdata[14:3] == 12'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("reserved bits set");
    property p_pulse; $rose(clock_output_pin) |=> periph_clk_en; endproperty
    a_pulse: assert property (p_pulse) else $error("no peripheral pulse");
    property p_idle; core_clk_en |-> periph_clk_en; endproperty
    a_idle: assert property (p_idle) else $error("core pulse alone");
    property p_run;
        periph_clk_en && !core_idle && !$past(core_idle) |-> core_clk_en;
    endproperty
    a_run: assert property (p_run) else $error("core pulse missing");
    property p_undiv; wr_c && undiv |-> ##3 $changed(clock_output_pin)[*4]; endproperty
    a_undiv: assert property (p_undiv) else $error("not undivided");
    property p_by4;
        wr_c && pwdata[15] && pwdata[2:0] == 3'h1 |-> ##[1:12]
        ($rose(clock_output_pin) ##1 clock_output_pin[*3] ##1 !clock_output_pin);
    endproperty
    a_by4: assert property (p_by4) else $error("by four half wrong");
    property p_exit;
        irq_to_core ##1 third_bus_state_fall |-> ##3 $changed(clock_output_pin)[*4];
    endproperty
    a_exit: assert property (p_exit) else $error("no exit to full speed");
    c_exit: cover property (irq_to_core ##1 third_bus_state_fall);
    c_idle: cover property (core_idle && periph_clk_en);
    c_err: cover property (pslverr);
endmodule : psc_chk

bind psc_top psc_chk u_psc_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
    .irq_to_core(irq_to_core), .third_bus_state_fall(third_bus_state_fall),
    .core_idle(core_idle), .clock_output_pin(clock_output_pin),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en));

// ### dv/psc_top_tb.sv
`timescale 1ns/100ps
module psc_top_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        nmi_pin = 1'b0;
    logic        irq_to_core = 1'b0;
    logic        third_bus_state_fall = 1'b0;
    logic        core_idle = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clk_pin;
    logic        core_en;
    logic        per_en;
    logic [31:0] rdv;
    logic        errv;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          rat [8] = '{1, 4, 8, 16, 32, 64, 1, 1};
    localparam logic [7:0] CA = psc_pkg::CTRL_OFFSET;
    localparam logic [7:0] SA = psc_pkg::STATUS_OFFSET;
    always #5 pclk = ~pclk;
    psc_top u_psc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .irq_to_core(irq_to_core),
        .third_bus_state_fall(third_bus_state_fall), .core_idle(core_idle),
        .clock_output_pin(clk_pin), .core_clk_en(core_en), .periph_clk_en(per_en));
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one idle cycle before setup keeps each signal to one update per step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // the second high half is measured: the first may be cut short
    task hlen(input int exp);
        int n;
        repeat (2) begin
            n = 0;
            while (clk_pin !== 1'b0) @(posedge pclk);
            while (clk_pin !== 1'b1) @(posedge pclk);
            while (clk_pin === 1'b1) begin
                n++;
                @(posedge pclk);
            end
        end
        chk("half", 32'(n), 32'(exp));
    endtask : hlen
    task evt(input logic irq, input logic nmi);
        @(posedge pclk);
        irq_to_core <= irq;
        nmi_pin <= nmi;
        repeat (3) @(posedge pclk);
        // request is gone before software enters the mode again
        irq_to_core <= 1'b0;
        nmi_pin <= 1'b0;
        third_bus_state_fall <= 1'b1;
        @(posedge pclk);
        third_bus_state_fall <= 1'b0;
    endtask : evt
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        int nc;
        int np;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("err", 32'(errv), 32'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, CA, 32'h8000 | c);
            apb(1'b0, CA, 32'h0);
            chk("ctrl", rdv, 32'h8000 | c);
            hlen(rat[c]);
        end
        apb(1'b1, CA, 32'hffff_7ff5);
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h5);
        hlen(1);
        $display("test divide done");
        apb(1'b1, CA, 32'h8003);
        apb(1'b0, SA, 32'h0);
        chk("status", rdv & 32'h0000_04ff, 32'h0000_0410);
        evt(1'b1, 1'b0);
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h3);
        evt(1'b0, 1'b0);
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h3);
        hlen(1);
        apb(1'b1, CA, 32'h8002);
        evt(1'b0, 1'b1);
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h2);
        evt(1'b1, 1'b0);
        hlen(1);
        apb(1'b1, CA, 32'h8001);
        evt(1'b0, 1'b0);
        apb(1'b0, CA, 32'h0);
        chk("ctrl", rdv, 32'h8001);
        hlen(4);
        $display("test exit done");
        apb(1'b1, CA, 32'h0);
        core_idle <= 1'b1;
        nc = 0;
        np = 0;
        // the pulse seen first was launched before idle was raised
        @(posedge pclk);
        repeat (40) begin
            @(posedge pclk);
            nc += core_en;
            np += per_en;
        end
        core_idle <= 1'b0;
        chk("core", 32'(nc), 32'h0);
        chk("periph", 32'(np > 10), 32'h1);
        $display("test idle done");
        close_out();
    end
endmodule : psc_top_tb
